// file: dv/lcm_host.sv
// Host processor model on the parallel pins of the display controller.
// Assumes clk_i is the controller clock; the bench calls its tasks.
`timescale 1ns/1ps
module lcm_host (
	// Clock
	input  wire logic       clk_i,
	// Parallel pins
	input  wire logic [7:0] dat_i,
	input  wire logic       oe_i,
	output logic            e_o,
	output logic            sel_o,
	output logic            rw_o,
	output logic      [7:0] dat_o
);
	logic nib = 1'b0;
	int   cyc = 0;
	initial begin
		e_o = 1'b0;
		sel_o = 1'b0;
		rw_o = 1'b1;
		dat_o = 8'hA5;
	end
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
	end
	// One strobe; released lines show the inverse of the last value
	task automatic acc(input logic sel, input logic rw, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk_i);
		e_o   <= 1'b1;
		sel_o <= sel;
		rw_o  <= rw;
		dat_o <= rw ? ~dat_o : d;
		repeat (2) @(posedge clk_i);
		q = oe_i ? dat_i : ~dat_i;
		@(posedge clk_i);
		e_o <= 1'b0;
		@(posedge clk_i);
		dat_o <= ~dat_o;
	endtask
	// Byte transfer; upper nibble first in four-bit mode
	task automatic xfer(input logic sel, input logic rw, input logic [7:0] d,
		output logic [7:0] q);
		logic [7:0] h;
		logic [7:0] l;
		if (nib) begin
			acc(sel, rw, {d[7:4], ~dat_o[3:0]}, h);
			acc(sel, rw, {d[3:0], ~dat_o[3:0]}, l);
			q = {h[7:4], l[7:4]};
		end else begin
			acc(sel, rw, d, q);
		end
	endtask
	// Poll busy until clear; returns cycles spent
	task automatic poll(output int n);
		logic [7:0] s;
		int         t;
		t = cyc;
		s = 8'hFF;
		for (int k = 0; k < 2000 && s[7] !== 1'b0; k++) begin
			xfer(1'b0, 1'b1, 8'h00, s);
		end
		n = cyc - t;
	endtask
endmodule

// file: dv/tb_lcm_core.sv
// Bench for the character display command interface.
// Drives pins through the host model and registers over Wishbone.
`timescale 1ns/1ps
module tb_lcm_core;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_cyc = 1'b0;
	logic        wb_stb = 1'b0;
	logic        wb_we = 1'b0;
	logic [7:0]  wb_adr = 8'h00;
	logic [3:0]  wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h0;
	logic [31:0] wb_q;
	logic        wb_ack;
	logic        e;
	logic        sel;
	logic        rw;
	logic [7:0]  hd;
	logic [7:0]  dq;
	logic        doe;
	int          mismatches = 0;
	int          n_tests = 0;
	int          ticks = 0;
	int          n;
	logic [31:0] s;
	logic [31:0] s2;
	logic [7:0]  b;

	always #5 clk_i = ~clk_i;

	lcm_core #(.LONG_CYC(200)) i_lcm_core (.clk_i(clk_i), .rst_i(rst_i), .e_i(e),
		.register_select_line_i(sel), .rw_i(rw), .db_i(hd), .db_o(dq), .db_oe_o(doe),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_q), .wb_ack_o(wb_ack));
	lcm_host i_lcm_host (.clk_i(clk_i), .dat_i(dq), .oe_i(doe), .e_o(e), .sel_o(sel),
		.rw_o(rw), .dat_o(hd));

	task automatic end_sim;
		$display("Checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge clk_i) begin
		ticks <= ticks + 1;
		if (ticks == 99000) begin
			mismatches = mismatches + 1;
			end_sim();
		end
	end
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_tests++;
		if (got !== ex) begin
			$display("[ERR] %s expected %h seen %h", nm, ex, got);
			mismatches++;
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= we;
		wb_adr <= a;
		wb_dat <= d;
		wb_sel <= 4'hF;
		do begin
			@(posedge clk_i);
		end while (wb_ack !== 1'b1);
		q = wb_q;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask
	task automatic st(output logic [31:0] q);
		wb(1'b0, lcm_pkg::REG_STATUS, 32'h0, q);
	endtask
	task automatic peek(input logic [6:0] i, input logic [7:0] ex);
		logic [31:0] q;
		wb(1'b1, lcm_pkg::REG_PEEK, {25'h0, i}, q);
		wb(1'b0, lcm_pkg::REG_PEEK, 32'h0, q);
		chk("text cell", ex, q[15:8]);
	endtask
	task automatic cmd(input logic [7:0] c, input int lo, input int hi);
		int k;
		logic [7:0] q;
		i_lcm_host.xfer(1'b0, 1'b0, c, q);
		i_lcm_host.poll(k);
		chk("busy time", 1, k >= lo && k <= hi);
	endtask
	task automatic t_reset;
		st(s);
		chk("reset status", 32'h0000_8200, s);
		wb(1'b1, 8'h0C, 32'hFFFF_FFFF, s);
		wb(1'b0, 8'h0C, 32'h0, s);
		chk("unmapped", 32'h0, s);
		wb(1'b1, lcm_pkg::REG_STATUS, 32'h7F, s);
		st(s);
		chk("status ro", 32'h0000_8200, s);
		peek(7'h05, 8'h20);
	endtask
	task automatic t_data8;
		i_lcm_host.xfer(1'b1, 1'b0, 8'h48, b);
		i_lcm_host.xfer(1'b0, 1'b1, 8'h00, b);
		chk("busy status", 8'h81, b);
		i_lcm_host.xfer(1'b1, 1'b0, 8'h55, b);
		i_lcm_host.poll(n);
		chk("short busy", 1, n >= 3995 && n <= 4015);
		st(s);
		chk("address", 7'h01, s[6:0]);
		peek(7'h00, 8'h48);
		peek(7'h01, 8'h20);
		cmd(8'h80, 3995, 4015);
		i_lcm_host.xfer(1'b1, 1'b1, 8'h00, b);
		chk("data read", 8'h48, b);
		@(posedge clk_i);
		chk("bus released", 1'b0, doe);
		i_lcm_host.poll(n);
	endtask
	task automatic t_modes;
		st(s);
		cmd(8'h00, 0, 4015);
		st(s2);
		chk("undefined", s, s2);
		cmd(8'h0E, 3995, 4015);
		st(s);
		chk("display bits", 3'b011, {s[lcm_pkg::ST_BLINK], s[lcm_pkg::ST_CUR],
			s[lcm_pkg::ST_DISP]});
		cmd(8'h07, 3995, 4015);
		i_lcm_host.xfer(1'b0, 1'b1, 8'h00, b);
		chk("pin status", 8'h01, b);
		i_lcm_host.xfer(1'b1, 1'b0, 8'h4D, b);
		i_lcm_host.poll(n);
		st(s);
		chk("shift write", {7'h01, 7'h02}, {s[23:17], s[6:0]});
		cmd(8'h10, 3995, 4015);
		st(s);
		chk("cursor left", {7'h01, 7'h01}, {s[23:17], s[6:0]});
		cmd(8'h1C, 3995, 4015);
		st(s);
		chk("display right", {7'h00, 7'h01}, {s[23:17], s[6:0]});
		cmd(8'h02, 195, 215);
		st(s);
		chk("return home", 14'h0, {s[23:17], s[6:0]});
	endtask
	task automatic t_lines;
		cmd(8'h01, 195, 215);
		peek(7'h01, 8'h20);
		st(s);
		chk("clear home", 8'h00, {s[lcm_pkg::ST_GSEL], s[6:0]});
		cmd(8'h08, 3995, 4015);
		cmd(8'h3C, 3995, 4015);
		st(s);
		chk("tall font", 2'b01, {s[lcm_pkg::ST_FONT], s[lcm_pkg::ST_TWO]});
		cmd(8'hC0, 3995, 4015);
		st(s);
		chk("line two", 7'h40, s[6:0]);
		cmd(8'hA7, 3995, 4015);
		i_lcm_host.xfer(1'b1, 1'b0, 8'h31, b);
		i_lcm_host.poll(n);
		st(s);
		chk("line wrap", 7'h40, s[6:0]);
		cmd(8'h40, 3995, 4015);
		st(s);
		chk("glyph select", {1'b1, 7'h00}, {s[lcm_pkg::ST_GSEL], s[6:0]});
	endtask
	task automatic t_nibble;
		i_lcm_host.xfer(1'b0, 1'b0, 8'h20, b);
		i_lcm_host.nib = 1'b1;
		i_lcm_host.poll(n);
		st(s);
		chk("bus four", 1'b0, s[lcm_pkg::ST_BUS8]);
		cmd(8'h28, 3995, 4015);
		st(s);
		chk("function", 2'b01, {s[lcm_pkg::ST_BUS8], s[lcm_pkg::ST_TWO]});
		cmd(8'h80, 3995, 4015);
		i_lcm_host.xfer(1'b1, 1'b0, 8'h41, b);
		i_lcm_host.xfer(1'b0, 1'b1, 8'h00, b);
		chk("nibble status", 8'h81, b);
		i_lcm_host.poll(n);
		peek(7'h00, 8'h41);
		wb(1'b1, lcm_pkg::REG_CTRL, 32'h0000_0001, s);
		i_lcm_host.nib = 1'b0;
		st(s);
		chk("soft reset", 32'h0000_8200, s);
		peek(7'h00, 8'h20);
	endtask

	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_data8();
		t_modes();
		t_lines();
		t_nibble();
		end_sim();
	end
endmodule

// file: logic/lcm_busy_timer.sv
// Execution timer: holds busy for a short or long count after a start pulse.
// Assumes start_i is a one-cycle pulse in the clk_i domain.
`timescale 1ns/1ps
module lcm_busy_timer #(
	parameter int SHORT_CYC = lcm_pkg::SHORT_CYC,
	parameter int LONG_CYC  = lcm_pkg::LONG_CYC,
	parameter int CW        = $clog2((LONG_CYC > SHORT_CYC ? LONG_CYC : SHORT_CYC) + 1)
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Control
	input  wire logic start_i,
	input  wire logic long_i,
	output logic      busy_o
);
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (start_i) begin
			cnt_d = long_i ? CW'(LONG_CYC) : CW'(SHORT_CYC);
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - CW'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign busy_o = (cnt_q != '0);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_busy_short_len: assert property (start_i && !long_i |=> cnt_q == CW'(SHORT_CYC))
		else $error("short execution count wrong");
	a_busy_long_len: assert property (start_i && long_i |=> cnt_q == CW'(LONG_CYC))
		else $error("long execution count wrong");
endmodule

// file: logic/lcm_core.sv
// Character display command interface: parallel host pins and register port.
// Pins are synchronous to clk_i; registers are a classic Wishbone slave.
`timescale 1ns/1ps
// Overview of operation
// - Reset selects eight-bit bus mode
// - Reset-mode function set completes in one write
// - Four-bit mode pairs two accesses per transfer
// - Select and direction pick the four operations
// - Status read drives busy on top bit
// - While busy, only status reads are taken
// - Busy lasts 40 us to 1.6 ms
// - Undefined code changes nothing, brief busy
// - Tall font refused with two lines
// - Reset selects blank text memory
// - Increment entry advances address by one
// - Shift entry moves window on text memory writes
// - Display control sets display and cursor bits
// - Shift command moves cursor or window
// - Two-line address jumps after position forty
// - Address 40 hex is second line start
// - Window shift rotates each line alone
// - Return home zeroes address and window
// - Address commands load pointer and memory select
// - Bus width bit picks eight or four lines
module lcm_core #(
	parameter int LONG_CYC = lcm_pkg::LONG_CYC
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Host parallel pins
	input  wire logic        e_i,
	input  wire logic        register_select_line_i,
	input  wire logic        rw_i,
	input  wire logic [7:0]  db_i,
	output logic      [7:0]  db_o,
	output logic             db_oe_o,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o
);
	lcm_pkg::lcm_ps_t ps_q, ps_d;
	logic       sel_q, sel_d, rw_q, rw_d, nib_q, nib_d;
	logic       bus8_q, bus8_d, two_q, two_d, font_q, font_d;
	logic       disp_q, disp_d, cur_q, cur_d, blink_q, blink_d;
	logic       inc_q, inc_d, shen_q, shen_d, gsel_q, gsel_d;
	logic [3:0] hi_q, hi_d;
	logic [6:0] ram_address_pointer_q, ram_address_pointer_d;
	logic [6:0] win_q, win_d;
	logic [7:0] rdl_q, rdl_d, db_q, db_d;
	logic       oe_q, oe_d;
	logic       fall, take, done, mw_en, clr, go, go_long;
	logic [7:0] full, rd_mem, rd_byte;
	logic       internal_busy_flag;
	logic [7:0] display_text_memory [lcm_pkg::TXT_DEPTH];
	logic [7:0] glyph_pattern_memory [lcm_pkg::GLY_DEPTH];
	logic       ack_q, ack_d, srst_q, srst_d;
	logic [31:0] wdat_q, wdat_d;
	logic [6:0] peek_q, peek_d;
	logic       rst_all;

	assign rst_all = rst_i || srst_q;

	function automatic logic [6:0] adv_addr(input logic [6:0] a, input logic up,
			input logic two, input logic gly);
		logic [6:0] r;
		r = up ? a + 7'h01 : a - 7'h01;
		if (gly) begin
			r = {1'b0, r[5:0]};
		end else if (two) begin
			if (up && a == lcm_pkg::L1_LAST_2L) r = lcm_pkg::L2_FIRST;
			if (up && a == lcm_pkg::L2_LAST) r = 7'h00;
			if (!up && a == 7'h00) r = lcm_pkg::L2_LAST;
			if (!up && a == lcm_pkg::L2_FIRST) r = lcm_pkg::L1_LAST_2L;
		end else begin
			if (up && a == lcm_pkg::L1_LAST_1L) r = 7'h00;
			if (!up && a == 7'h00) r = lcm_pkg::L1_LAST_1L;
		end
		return r;
	endfunction

	function automatic logic [6:0] adv_win(input logic [6:0] w, input logic left,
			input logic two);
		logic [6:0] len;
		len = two ? lcm_pkg::LEN_2L : lcm_pkg::LEN_1L;
		if (left) begin
			return (w == len - 7'h01) ? 7'h00 : w + 7'h01;
		end
		return (w == 7'h00) ? len - 7'h01 : w - 7'h01;
	endfunction

	assign rd_mem = gsel_q ? glyph_pattern_memory[ram_address_pointer_q[5:0]]
		: display_text_memory[ram_address_pointer_q];
	assign rd_byte = register_select_line_i ? rd_mem
		: {internal_busy_flag, ram_address_pointer_q};

	lcm_busy_timer #(
		.SHORT_CYC (lcm_pkg::SHORT_CYC),
		.LONG_CYC  (LONG_CYC),
		.CW        ($clog2((LONG_CYC > lcm_pkg::SHORT_CYC ? LONG_CYC
			: lcm_pkg::SHORT_CYC) + 1))
	) i_lcm_busy_timer (
		.clk_i   (clk_i),
		.rst_i   (rst_all),
		.start_i (go),
		.long_i  (go_long),
		.busy_o  (internal_busy_flag)
	);

	// Pin sequencer and command execution
	always_comb begin
		ps_d = ps_q;
		sel_d = sel_q;
		rw_d = rw_q;
		nib_d = nib_q;
		hi_d = hi_q;
		rdl_d = rdl_q;
		bus8_d = bus8_q;
		two_d = two_q;
		font_d = font_q;
		disp_d = disp_q;
		cur_d = cur_q;
		blink_d = blink_q;
		inc_d = inc_q;
		shen_d = shen_q;
		gsel_d = gsel_q;
		ram_address_pointer_d = ram_address_pointer_q;
		win_d = win_q;
		fall = 1'b0;
		done = 1'b0;
		mw_en = 1'b0;
		clr = 1'b0;
		go = 1'b0;
		go_long = 1'b0;
		full = bus8_q ? db_i : {hi_q, db_i[7:4]};
		unique case (ps_q)
			lcm_pkg::PS_IDLE: if (e_i) begin
				ps_d = lcm_pkg::PS_STROBE;
				sel_d = register_select_line_i;
				rw_d = rw_i;
			end
			lcm_pkg::PS_STROBE: if (!e_i) begin
				ps_d = lcm_pkg::PS_IDLE;
				fall = 1'b1;
			end
		endcase
		take = fall && (!internal_busy_flag || (!sel_q && rw_q));
		if (take) begin
			if (!bus8_q && !nib_q) begin
				nib_d = 1'b1;
				hi_d = db_i[7:4];
				rdl_d = sel_q ? rd_mem : {internal_busy_flag, ram_address_pointer_q};
			end else begin
				nib_d = 1'b0;
				done = 1'b1;
			end
		end
		if (done) begin
			unique case ({sel_q, rw_q})
				2'b11: begin
					ram_address_pointer_d = adv_addr(ram_address_pointer_q, inc_q, two_q,
						gsel_q);
					go = 1'b1;
				end
				2'b10: begin
					mw_en = 1'b1;
					ram_address_pointer_d = adv_addr(ram_address_pointer_q, inc_q, two_q,
						gsel_q);
					if (shen_q && !gsel_q) begin
						win_d = adv_win(win_q, inc_q, two_q);
					end
					go = 1'b1;
				end
				2'b01: begin
				end
				2'b00: begin
					go = 1'b1;
					casez (full)
						8'b1???????: begin
							ram_address_pointer_d = full[6:0];
							gsel_d = 1'b0;
						end
						8'b01??????: begin
							ram_address_pointer_d = {1'b0, full[5:0]};
							gsel_d = 1'b1;
						end
						8'b001?????: begin
							bus8_d = full[4];
							two_d = full[3];
							font_d = full[2] && !full[3];
						end
						8'b0001????: begin
							if (full[3]) begin
								win_d = adv_win(win_q, !full[2], two_q);
							end else begin
								ram_address_pointer_d = adv_addr(ram_address_pointer_q,
									full[2], two_q, gsel_q);
							end
						end
						8'b00001???: begin
							disp_d = full[2];
							cur_d = full[1];
							blink_d = full[0];
						end
						8'b000001??: begin
							inc_d = full[1];
							shen_d = full[0];
						end
						8'b0000001?: begin
							ram_address_pointer_d = 7'h00;
							win_d = 7'h00;
							gsel_d = 1'b0;
							go_long = 1'b1;
						end
						lcm_pkg::CMD_CLEAR: begin
							clr = 1'b1;
							ram_address_pointer_d = 7'h00;
							win_d = 7'h00;
							gsel_d = 1'b0;
							inc_d = 1'b1;
							go_long = 1'b1;
						end
						default: begin
						end
					endcase
				end
			endcase
		end
		oe_d = e_i && rw_i;
		db_d = rd_byte;
		if (!bus8_q) begin
			db_d = nib_q ? {rdl_q[3:0], 4'h0} : {rd_byte[7:4], 4'h0};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_all) begin
			ps_q <= lcm_pkg::PS_IDLE;
			sel_q <= 1'b0;
			rw_q <= 1'b0;
			nib_q <= 1'b0;
			hi_q <= 4'h0;
			rdl_q <= 8'h00;
			bus8_q <= 1'b1;
			two_q <= 1'b0;
			font_q <= 1'b0;
			disp_q <= 1'b0;
			cur_q <= 1'b0;
			blink_q <= 1'b0;
			inc_q <= 1'b1;
			shen_q <= 1'b0;
			gsel_q <= 1'b0;
			ram_address_pointer_q <= 7'h00;
			win_q <= 7'h00;
			db_q <= 8'h00;
			oe_q <= 1'b0;
		end else begin
			ps_q <= ps_d;
			sel_q <= sel_d;
			rw_q <= rw_d;
			nib_q <= nib_d;
			hi_q <= hi_d;
			rdl_q <= rdl_d;
			bus8_q <= bus8_d;
			two_q <= two_d;
			font_q <= font_d;
			disp_q <= disp_d;
			cur_q <= cur_d;
			blink_q <= blink_d;
			inc_q <= inc_d;
			shen_q <= shen_d;
			gsel_q <= gsel_d;
			ram_address_pointer_q <= ram_address_pointer_d;
			win_q <= win_d;
			db_q <= db_d;
			oe_q <= oe_d;
		end
	end

	// Text memory: blank on reset and on clear
	always_ff @(posedge clk_i) begin
		if (rst_all || clr) begin
			for (int i = 0; i < lcm_pkg::TXT_DEPTH; i++) begin
				display_text_memory[i] <= lcm_pkg::BLANK_CODE;
			end
		end else if (mw_en && !gsel_q) begin
			display_text_memory[ram_address_pointer_q] <= full;
		end
	end

	always_ff @(posedge clk_i) begin
		if (mw_en && gsel_q) begin
			glyph_pattern_memory[ram_address_pointer_q[5:0]] <= full;
		end
	end

	// Wishbone register port
	always_comb begin
		ack_d = wb_cyc_i && wb_stb_i && !ack_q;
		srst_d = 1'b0;
		peek_d = peek_q;
		wdat_d = 32'h0000_0000;
		if (ack_d) begin
			unique case (wb_adr_i)
				lcm_pkg::REG_STATUS: begin
					wdat_d[6:0] = ram_address_pointer_q;
					wdat_d[lcm_pkg::ST_BUSY] = internal_busy_flag;
					wdat_d[lcm_pkg::ST_GSEL] = gsel_q;
					wdat_d[lcm_pkg::ST_BUS8] = bus8_q;
					wdat_d[lcm_pkg::ST_TWO] = two_q;
					wdat_d[lcm_pkg::ST_FONT] = font_q;
					wdat_d[lcm_pkg::ST_DISP] = disp_q;
					wdat_d[lcm_pkg::ST_CUR] = cur_q;
					wdat_d[lcm_pkg::ST_BLINK] = blink_q;
					wdat_d[lcm_pkg::ST_INC] = inc_q;
					wdat_d[lcm_pkg::ST_SHEN] = shen_q;
					wdat_d[lcm_pkg::ST_WIN +: 7] = win_q;
				end
				lcm_pkg::REG_CTRL: begin
					srst_d = wb_we_i && wb_sel_i[0] && wb_dat_i[0];
				end
				lcm_pkg::REG_PEEK: begin
					if (wb_we_i && wb_sel_i[0]) begin
						peek_d = wb_dat_i[6:0];
					end
					wdat_d[6:0] = peek_q;
					wdat_d[lcm_pkg::PK_DATA +: 8] = display_text_memory[peek_q];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			srst_q <= 1'b0;
			peek_q <= 7'h00;
			wdat_q <= 32'h0000_0000;
		end else begin
			ack_q <= ack_d;
			srst_q <= srst_d;
			peek_q <= peek_d;
			wdat_q <= wdat_d;
		end
	end

	assign db_o = db_q;
	assign db_oe_o = oe_q;
	assign wb_ack_o = ack_q;
	assign wb_dat_o = wdat_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_all);

	a_reset_wide_bus: assert property (ps_q == lcm_pkg::PS_IDLE && $past(rst_i)
		|-> bus8_q && !gsel_q && !nib_q)
		else $error("reset state not eight-bit text mode");
	a_nibble_pair: assert property (take && !bus8_q && !nib_q |=> nib_q ##0 !go)
		else $error("first nibble did not wait for second");
	a_upper_first: assert property (take && !bus8_q && !nib_q
		|=> hi_q == $past(db_i[7:4]))
		else $error("upper nibble not held");
	a_status_top: assert property (e_i && rw_i && !register_select_line_i && bus8_q
		|=> db_oe_o && db_o[7] == $past(internal_busy_flag))
		else $error("busy not on top bus bit");
	a_busy_ignore: assert property (fall && internal_busy_flag && !(!sel_q && rw_q)
		|=> $stable(ram_address_pointer_q) && $stable(nib_q))
		else $error("strobe taken while busy");
	a_undef_noop: assert property (done && !sel_q && !rw_q && full == lcm_pkg::CMD_UNDEF
		|=> $stable(two_q) && $stable(ram_address_pointer_q) && internal_busy_flag)
		else $error("undefined code changed state");
	a_font_refused: assert property (two_q |-> !font_q)
		else $error("tall font with two lines");
	a_inc_step: assert property (done && sel_q && !rw_q && inc_q && !two_q && !gsel_q
		&& ram_address_pointer_q < lcm_pkg::L1_LAST_1L
		|=> ram_address_pointer_q == $past(ram_address_pointer_q) + 7'h01)
		else $error("data write did not advance by one");
	a_line_jump: assert property (done && sel_q && !rw_q && inc_q && two_q && !gsel_q
		&& ram_address_pointer_q == lcm_pkg::L1_LAST_2L
		|=> ram_address_pointer_q == lcm_pkg::L2_FIRST)
		else $error("no jump to second line");
	a_home_zero: assert property (done && !sel_q && !rw_q && full[7:1] == 7'h01
		|=> ram_address_pointer_q == 7'h00 && win_q == 7'h00 ##1 internal_busy_flag)
		else $error("return home did not reach zero");

	c_nibble_write: cover property (take && !bus8_q && nib_q && sel_q && !rw_q);
	c_poll_busy: cover property (take && internal_busy_flag && !sel_q && rw_q);
	c_clear: cover property (clr);
endmodule

// file: logic/lcm_pkg.sv
// Constants shared by the character display command interface.
// Assumes one 100 MHz clock and a Wishbone register port.
package lcm_pkg;
	// Timing
	localparam int CLK_MHZ    = 100;
	localparam int T_SHORT_NS = 40000;
	localparam int T_LONG_NS  = 1600000;
	localparam int SHORT_CYC  = T_SHORT_NS * CLK_MHZ / 1000;
	localparam int LONG_CYC   = T_LONG_NS * CLK_MHZ / 1000;
	// Memory layout
	localparam int TXT_DEPTH   = 128;
	localparam int GLY_DEPTH   = 64;
	localparam logic [7:0] BLANK_CODE = 8'h20;
	localparam logic [6:0] L1_LAST_1L = 7'h4F;
	localparam logic [6:0] L1_LAST_2L = 7'h27;
	localparam logic [6:0] L2_FIRST   = 7'h40;
	localparam logic [6:0] L2_LAST    = 7'h67;
	localparam logic [6:0] LEN_1L     = 7'h50;
	localparam logic [6:0] LEN_2L     = 7'h28;
	// Command codes
	localparam logic [7:0] CMD_CLEAR  = 8'h01;
	localparam logic [7:0] CMD_UNDEF  = 8'h00;
	// Register offsets
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_CTRL   = 8'h04;
	localparam logic [7:0] REG_PEEK   = 8'h08;
	// Status and peek field positions
	localparam int ST_BUSY  = 7;
	localparam int ST_GSEL  = 8;
	localparam int ST_BUS8  = 9;
	localparam int ST_TWO   = 10;
	localparam int ST_FONT  = 11;
	localparam int ST_DISP  = 12;
	localparam int ST_CUR   = 13;
	localparam int ST_BLINK = 14;
	localparam int ST_INC   = 15;
	localparam int ST_SHEN  = 16;
	localparam int ST_WIN   = 17;
	localparam int PK_DATA  = 8;
	// Pin sequencer states
	typedef enum logic {PS_IDLE, PS_STROBE} lcm_ps_t;
endpackage
